//--- core/ubr_external_data_space_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubr_consts.svh"
// Functional notes
// R1 - Shared 512-byte RAM spans FD80 to FF7F.
// R2 - FF80 to FFFF goes to mapped registers, never to RAM.
// R3 - General data buffers, 368 bytes, FD80 to FEEF.
// R4 - Host-to-device endpoint-0 buffer at FEF0 to FEF7.
// R5 - Device-to-host endpoint-0 buffer at FEF8 to FEFF.
// R6 - Eight-byte setup packet stored at FF00 to FF07.
// R7 - Output endpoint 1 to 3 descriptors at FF08, FF10, FF18.
// R8 - Input endpoint 1 to 3 descriptors at FF48, FF50, FF58.
// R9 - Endpoint-0 descriptor lives in registers; endpoints 1 to 3 in RAM.
// R10 - Entry 0 config, entry 1 X base, entry 2 X count.
// R11 - Entry 5 Y base, 6 Y count, 7 size; 3 and 4 unused.
// R12 - Endpoint-0 config and count at FF80 to FF83.
// R13 - USB control, mask, status, function address at FFFC to FFFF.
// R14 - Interrupt delay FF84, MCU config FF90, vector FF92, watchdog FF93.
// R15 - Port pull-up registers at FF94 to FF97.
// R16 - Serial bus registers FFF0 to FFF3, identification status FFF6.
// R17 - Buffer base byte holds A10..A3; start address appends three zeros.
// R18 - Reserved register addresses read zero and ignore writes.

module ubr_external_data_space_decoder
	import ubr_pkg::*;
#(
	parameter int RAM_DEPTH = `UBR_RAM_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic [15:0]      cpu_addr,
	input  wire logic             cpu_rd,
	input  wire logic             cpu_wr,
	input  wire logic [7:0]       cpu_wdata,
	output logic                  cpu_hit,
	output logic [7:0]            cpu_rdata,
	input  wire logic             eng_req,
	input  wire logic             eng_we,
	input  wire logic             eng_desc,
	input  wire ubr_desc_sel_type eng_sel,
	input  wire logic [8:0]       eng_addr,
	input  wire logic [7:0]       eng_wdata,
	output logic                  eng_ready,
	output logic                  eng_rvalid,
	output logic [7:0]            eng_rdata,
	output logic [10:0]           eng_buf_start,
	input  wire logic [7:0]       sb_data_in,
	input  wire logic [7:0]       id_status_in,
	output ubr_reg_file_type      reg_out,
	output ubr_wr_event_type      reg_wr
);

	typedef struct packed {
		ubr_reg_file_type regs;
		logic [7:0]       reg_q;
		logic             rd_ram;
		logic             eng_rvalid;
		ubr_wr_event_type wr_ev;
	} ubr_dec_state_type;

	ubr_dec_state_type st;
	ubr_dec_state_type next_st;
	ubr_reg_sel_type   sel;
	ubr_ram_port_type  ram_a;
	ubr_ram_port_type  ram_b;
	logic [7:0]        q_a;
	logic [7:0]        q_b;
	logic [8:0]        eng_idx;
	logic              desc_bad;
	logic              collide;
	logic [15:0]       ram_off;

	function automatic logic in_ram(input logic [15:0] a);
		return (a >= `UBR_RAM_BASE) && (a <= `UBR_RAM_TOP);
	endfunction

	function automatic logic in_mmr(input logic [15:0] a);
		return a >= `UBR_MMR_BASE;
	endfunction

	function automatic ubr_reg_sel_type reg_decode(input logic [15:0] a);
		ubr_reg_sel_type s;
		s.hit = 1'b1;
		s.idx = reg_in_ep0_config;
		case (a)
		`UBR_ADR_IN_EP0_CFG: s.idx = reg_in_ep0_config; // R12
		`UBR_ADR_IN_EP0_CNT: s.idx = reg_in_ep0_byte_count; // R12
		`UBR_ADR_OUT_EP0_CFG: s.idx = reg_out_ep0_config; // R12
		`UBR_ADR_OUT_EP0_CNT: s.idx = reg_out_ep0_byte_count; // R12
		`UBR_ADR_INT_DELAY: s.idx = reg_interrupt_delay_config; // R14
		`UBR_ADR_MCU_CFG: s.idx = reg_mcu_config; // R14
		`UBR_ADR_INT_VECTOR: s.idx = reg_interrupt_vector; // R14
		`UBR_ADR_WDOG: s.idx = reg_watchdog_ctrl_status; // R14
		`UBR_ADR_PORT0_PU: s.idx = reg_port0_pullup; // R15
		`UBR_ADR_PORT1_PU: s.idx = reg_port1_pullup; // R15
		`UBR_ADR_PORT2_PU: s.idx = reg_port2_pullup; // R15
		`UBR_ADR_PORT3_PU: s.idx = reg_port3_pullup; // R15
		`UBR_ADR_SB_STATUS: s.idx = reg_serial_bus_status_ctrl; // R16
		`UBR_ADR_SB_DOUT: s.idx = reg_serial_bus_data_out; // R16
		`UBR_ADR_SB_DIN: s.idx = reg_serial_bus_data_in; // R16
		`UBR_ADR_SB_TARGET: s.idx = reg_serial_bus_target_addr; // R16
		`UBR_ADR_ID_STATUS: s.idx = reg_product_id_status; // R16
		`UBR_ADR_USB_CTRL: s.idx = reg_usb_control; // R13
		`UBR_ADR_USB_MASK: s.idx = reg_usb_interrupt_mask; // R13
		`UBR_ADR_USB_STATUS: s.idx = reg_usb_status; // R13
		`UBR_ADR_FUNC_ADDR: s.idx = reg_usb_function_address; // R13
		default: s.hit = 1'b0; // R18
		endcase
		return s;
	endfunction

	// RAM index of one descriptor entry of endpoint 1 to 3
	function automatic logic [8:0] desc_index(input ubr_desc_sel_type s);
		logic [15:0] base;
		logic [15:0] a;
		base = s.dir ? `UBR_IN_DESC_BASE : `UBR_OUT_DESC_BASE; // R7 R8
		a = base + {11'h000, s.ep - 2'd1, 3'h0} + {13'h0000, s.field}; // R10 R11
		a = a - `UBR_RAM_BASE;
		return a[8:0];
	endfunction

	// CPU side decode
	assign sel = reg_decode(cpu_addr);
	assign cpu_hit = in_ram(cpu_addr) || in_mmr(cpu_addr);
	assign ram_off = cpu_addr - `UBR_RAM_BASE;

	always_comb begin
		ram_a.en = (cpu_rd || cpu_wr) && in_ram(cpu_addr); // R1 R2
		ram_a.we = cpu_wr;
		ram_a.addr = ram_off[8:0]; // R3 R4 R5 R6
		ram_a.wdata = cpu_wdata;
	end

	// Engine side: raw buffer index or descriptor entry
	assign desc_bad = eng_desc && (eng_sel.ep == 2'd0); // R9
	assign eng_idx = eng_desc ? desc_index(eng_sel) : eng_addr;
	assign collide = ram_a.en && ram_a.we && eng_we && (eng_idx == ram_a.addr);
	assign eng_ready = !desc_bad && !collide;

	always_comb begin
		ram_b.en = eng_req && eng_ready;
		ram_b.we = eng_we;
		ram_b.addr = eng_idx;
		ram_b.wdata = eng_wdata;
	end

	ubr_shared_ram #(
		.DEPTH (RAM_DEPTH)
	) u_ram (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.port_a  (ram_a),
		.port_b  (ram_b),
		.q_a     (q_a),
		.q_b     (q_b)
	);

	always_comb begin
		next_st = st;
		next_st.rd_ram = 1'b0;
		next_st.eng_rvalid = eng_req && eng_ready && !eng_we;
		next_st.wr_ev.valid = 1'b0;
		if (cpu_wr) begin
			if (sel.hit && sel.idx != reg_serial_bus_data_in
			    && sel.idx != reg_product_id_status) begin
				next_st.regs[sel.idx] = cpu_wdata; // R12 R13 R14 R15 R16
			end
			if (sel.hit) begin
				next_st.wr_ev.valid = 1'b1;
				next_st.wr_ev.idx = sel.idx;
				next_st.wr_ev.data = cpu_wdata;
			end
		end else if (cpu_rd) begin
			if (in_ram(cpu_addr)) begin
				next_st.rd_ram = 1'b1; // R1
			end else if (!sel.hit) begin
				next_st.reg_q = 8'h00; // R18
			end else if (sel.idx == reg_serial_bus_data_in) begin
				next_st.reg_q = sb_data_in; // R16
			end else if (sel.idx == reg_product_id_status) begin
				next_st.reg_q = id_status_in; // R16
			end else begin
				next_st.reg_q = st.regs[sel.idx]; // R2
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st.regs <= {`UBR_NUM_REGS{`UBR_REG_RESET}};
			st.reg_q <= 8'h00;
			st.rd_ram <= 1'b0;
			st.eng_rvalid <= 1'b0;
			st.wr_ev <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cpu_rdata = st.rd_ram ? q_a : st.reg_q;
	assign eng_rvalid = st.eng_rvalid;
	assign eng_rdata = q_b;
	assign eng_buf_start = {q_b, 3'b000}; // R17
	assign reg_out = st.regs;
	assign reg_wr = st.wr_ev;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	chk_ram_read_route: assert property ( // R1
		cpu_rd && !cpu_wr && in_ram(cpu_addr) |-> ram_a.en ##1 st.rd_ram)
		else $error("RAM range read not routed to RAM");

	chk_mmr_no_ram: assert property ( // R2
		in_mmr(cpu_addr) |-> !ram_a.en ##1 !st.rd_ram)
		else $error("Register range reached the RAM");

	chk_data_buf_span: assert property ( // R3
		(cpu_wr && cpu_addr >= `UBR_DATA_BUF_BASE
		 && cpu_addr <= `UBR_DATA_BUF_TOP)
		|-> ram_a.en && ram_a.addr < 9'd368)
		else $error("Data buffer index out of span");

	chk_out_ep0_buf: assert property ( // R4
		(cpu_wr && cpu_addr[15:3] == 13'h1fde)
		|-> ram_a.addr[8:3] == 6'h2e)
		else $error("Endpoint-0 receive buffer misplaced");

	chk_in_ep0_buf: assert property ( // R5
		(cpu_wr && cpu_addr[15:3] == 13'h1fdf)
		|-> ram_a.addr[8:3] == 6'h2f)
		else $error("Endpoint-0 transmit buffer misplaced");

	chk_setup_buf: assert property ( // R6
		(cpu_rd && cpu_addr[15:3] == 13'h1fe0)
		|-> ram_a.en && ram_a.addr[8:3] == 6'h30)
		else $error("Setup packet misplaced");

	chk_out_desc_base: assert property ( // R7
		(eng_req && eng_desc && !eng_sel.dir && eng_sel.ep == 2'd1
		 && eng_sel.field == 3'd0) |-> ram_b.addr == 9'h188)
		else $error("Output endpoint 1 descriptor misplaced");

	chk_out_desc_ep3: assert property ( // R7
		(eng_req && eng_desc && !eng_sel.dir && eng_sel.ep == 2'd3
		 && eng_sel.field == 3'd2) |-> eng_idx == 9'h19a)
		else $error("Output endpoint 3 count entry misplaced");

	chk_in_desc_ep3: assert property ( // R8
		(eng_desc && eng_sel.dir && eng_sel.ep == 2'd3
		 && eng_sel.field == 3'd7) |-> eng_idx == 9'h1df)
		else $error("Input endpoint 3 size entry misplaced");

	chk_in_y_base: assert property ( // R11
		(eng_desc && eng_sel.dir && eng_sel.ep == 2'd2
		 && eng_sel.field == 3'd5) |-> eng_idx == 9'h1d5)
		else $error("Y base entry misplaced");

	chk_ep0_no_desc: assert property ( // R9
		eng_req && eng_desc && eng_sel.ep == 2'd0
		|-> !eng_ready ##1 !st.eng_rvalid)
		else $error("Endpoint-0 descriptor reached RAM");

	chk_ep0_cfg_write: assert property ( // R12
		cpu_wr && cpu_addr == `UBR_ADR_OUT_EP0_CFG
		|=> reg_out[reg_out_ep0_config] == $past(cpu_wdata))
		else $error("Endpoint-0 config write lost");

	chk_func_addr_rd: assert property ( // R13
		cpu_wr && cpu_addr == `UBR_ADR_FUNC_ADDR
		##1 cpu_rd && !cpu_wr && cpu_addr == `UBR_ADR_FUNC_ADDR
		|=> cpu_rdata == $past(cpu_wdata, 2))
		else $error("Function address readback wrong");

	chk_sb_din_read: assert property ( // R16
		cpu_rd && !cpu_wr && cpu_addr == `UBR_ADR_SB_DIN
		|=> cpu_rdata == $past(sb_data_in))
		else $error("Serial data-in not reflected");

	chk_buf_start_pad: assert property ( // R17
		st.eng_rvalid |-> eng_buf_start[2:0] == 3'b000
		&& eng_buf_start[10:3] == eng_rdata)
		else $error("Buffer start address not padded");

	chk_reserved_zero: assert property ( // R18
		cpu_rd && !cpu_wr && in_mmr(cpu_addr) && !sel.hit
		|=> cpu_rdata == 8'h00 && $stable(reg_out))
		else $error("Reserved address returned data");

	chk_reserved_nowr: assert property ( // R18
		cpu_wr && in_mmr(cpu_addr) && !sel.hit
		|=> $stable(reg_out) && !reg_wr.valid)
		else $error("Reserved address write took effect");

	chk_out_x_base: assert property ( // R10
		(eng_desc && !eng_sel.dir && eng_sel.ep == 2'd2
		 && eng_sel.field == 3'd1) |-> eng_idx == 9'h191)
		else $error("X base entry misplaced");

	chk_in_x_count: assert property ( // R10
		(eng_desc && eng_sel.dir && eng_sel.ep == 2'd1
		 && eng_sel.field == 3'd2) |-> eng_idx == 9'h1ca)
		else $error("X count entry misplaced");

	chk_eng_read_ans: assert property ( // R1
		eng_req && eng_ready && !eng_we |=> eng_rvalid)
		else $error("Engine read not answered");

	chk_eng_no_ans: assert property ( // R1
		!(eng_req && eng_ready && !eng_we) |=> !eng_rvalid)
		else $error("Engine answer without a read");

	chk_collide_stall: assert property ( // R1
		cpu_wr && in_ram(cpu_addr) && eng_req && eng_we
		&& !eng_desc && eng_addr == ram_off[8:0] |-> !eng_ready)
		else $error("Engine write not stalled on collision");

	chk_ram_write_land: assert property ( // R1
		cpu_wr && in_ram(cpu_addr)
		##1 cpu_rd && !cpu_wr && cpu_addr == $past(cpu_addr)
		|=> cpu_rdata == $past(cpu_wdata, 2))
		else $error("RAM write not read back");

	chk_mask_wr_event: assert property ( // R13
		cpu_wr && cpu_addr == `UBR_ADR_USB_MASK
		|=> reg_wr.valid && reg_wr.idx == reg_usb_interrupt_mask
		&& reg_wr.data == $past(cpu_wdata))
		else $error("Mask write event wrong");

	chk_id_not_stored: assert property ( // R16
		cpu_wr && cpu_addr == `UBR_ADR_ID_STATUS |=> $stable(reg_out))
		else $error("Identification status was stored");

	cov_ram_read: cover property (
		cpu_rd && in_ram(cpu_addr) ##1 st.rd_ram);

	cov_desc_read: cover property (
		eng_req && eng_desc && eng_ready && !eng_we ##1 st.eng_rvalid);

	cov_collision: cover property (collide && eng_req);

	cov_reg_write: cover property (reg_wr.valid);

	cov_back_to_back: cover property (cpu_wr ##1 cpu_rd);

endmodule // ubr_external_data_space_decoder
`default_nettype wire

//--- core/ubr_consts.svh
`ifndef UBR_CONSTS_SVH
`define UBR_CONSTS_SVH

// Shared RAM window
`define UBR_RAM_BASE       16'hfd80
`define UBR_RAM_TOP        16'hff7f
`define UBR_RAM_DEPTH      512
`define UBR_RAM_AW         9

// Regions inside the shared RAM
`define UBR_DATA_BUF_BASE  16'hfd80
`define UBR_DATA_BUF_TOP   16'hfeef
`define UBR_DATA_BUF_BYTES 368
`define UBR_OUT_EP0_BUF    16'hfef0
`define UBR_IN_EP0_BUF     16'hfef8
`define UBR_SETUP_BUF      16'hff00
`define UBR_OUT_DESC_BASE  16'hff08
`define UBR_IN_DESC_BASE   16'hff48
`define UBR_DESC_BYTES     8

// Descriptor entry offsets
`define UBR_ENT_CONFIG     3'h0
`define UBR_ENT_X_BASE     3'h1
`define UBR_ENT_X_COUNT    3'h2
`define UBR_ENT_Y_BASE     3'h5
`define UBR_ENT_Y_COUNT    3'h6
`define UBR_ENT_XY_SIZE    3'h7

// Mapped register range
`define UBR_MMR_BASE       16'hff80
`define UBR_ADR_IN_EP0_CFG 16'hff80
`define UBR_ADR_IN_EP0_CNT 16'hff81
`define UBR_ADR_OUT_EP0_CFG 16'hff82
`define UBR_ADR_OUT_EP0_CNT 16'hff83
`define UBR_ADR_INT_DELAY  16'hff84
`define UBR_ADR_MCU_CFG    16'hff90
`define UBR_ADR_INT_VECTOR 16'hff92
`define UBR_ADR_WDOG       16'hff93
`define UBR_ADR_PORT0_PU   16'hff94
`define UBR_ADR_PORT1_PU   16'hff95
`define UBR_ADR_PORT2_PU   16'hff96
`define UBR_ADR_PORT3_PU   16'hff97
`define UBR_ADR_SB_STATUS  16'hfff0
`define UBR_ADR_SB_DOUT    16'hfff1
`define UBR_ADR_SB_DIN     16'hfff2
`define UBR_ADR_SB_TARGET  16'hfff3
`define UBR_ADR_ID_STATUS  16'hfff6
`define UBR_ADR_USB_CTRL   16'hfffc
`define UBR_ADR_USB_MASK   16'hfffd
`define UBR_ADR_USB_STATUS 16'hfffe
`define UBR_ADR_FUNC_ADDR  16'hffff

`define UBR_NUM_REGS       21
`define UBR_REG_RESET      8'h00

`endif

//--- core/ubr_pkg.sv
`include "ubr_consts.svh"

package ubr_pkg;

	typedef enum logic [4:0] {
		reg_in_ep0_config,
		reg_in_ep0_byte_count,
		reg_out_ep0_config,
		reg_out_ep0_byte_count,
		reg_interrupt_delay_config,
		reg_mcu_config,
		reg_interrupt_vector,
		reg_watchdog_ctrl_status,
		reg_port0_pullup,
		reg_port1_pullup,
		reg_port2_pullup,
		reg_port3_pullup,
		reg_serial_bus_status_ctrl,
		reg_serial_bus_data_out,
		reg_serial_bus_data_in,
		reg_serial_bus_target_addr,
		reg_product_id_status,
		reg_usb_control,
		reg_usb_interrupt_mask,
		reg_usb_status,
		reg_usb_function_address
	} ubr_reg_id_type;

	typedef logic [`UBR_NUM_REGS-1:0][7:0] ubr_reg_file_type;

	typedef struct packed {
		logic           hit;
		ubr_reg_id_type idx;
	} ubr_reg_sel_type;

	typedef struct packed {
		logic                   en;
		logic                   we;
		logic [`UBR_RAM_AW-1:0] addr;
		logic [7:0]             wdata;
	} ubr_ram_port_type;

	typedef struct packed {
		logic       dir;
		logic [1:0] ep;
		logic [2:0] field;
	} ubr_desc_sel_type;

	typedef struct packed {
		logic           valid;
		ubr_reg_id_type idx;
		logic [7:0]     data;
	} ubr_wr_event_type;

endpackage

//--- core/ubr_shared_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubr_consts.svh"

module ubr_shared_ram
	import ubr_pkg::*;
#(
	parameter int DEPTH = `UBR_RAM_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire ubr_ram_port_type port_a,
	input  wire ubr_ram_port_type port_b,
	output logic [7:0]            q_a,
	output logic [7:0]            q_b
);

	typedef struct packed {
		logic [7:0] q_a;
		logic [7:0] q_b;
	} ubr_ram_state_type;

	ubr_ram_state_type st;
	ubr_ram_state_type next_st;
	logic [7:0]        mem [DEPTH];

	always_comb begin
		next_st = st;
		if (port_a.en && !port_a.we) begin
			next_st.q_a = mem[port_a.addr];
		end
		if (port_b.en && !port_b.we) begin
			next_st.q_b = mem[port_b.addr];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Port A is written last so it wins a same-address collision
	always_ff @(posedge sys_clk) begin
		if (port_b.en && port_b.we) begin
			mem[port_b.addr] <= port_b.wdata;
		end
		if (port_a.en && port_a.we) begin
			mem[port_a.addr] <= port_a.wdata;
		end
	end

	assign q_a = st.q_a;
	assign q_b = st.q_b;

endmodule // ubr_shared_ram
`default_nettype wire

//--- tb/ubr_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none

module ubr_mcu_model (
	input  wire logic [7:0] cpu_rdata,
	input  wire logic       sys_clk,
	output logic [15:0]     cpu_addr,
	output logic            cpu_rd,
	output logic            cpu_wr,
	output logic [7:0]      cpu_wdata
);
	initial begin
		cpu_addr = 16'hfd00;
		cpu_rd = 1'b0;
		cpu_wr = 1'b0;
		cpu_wdata = 8'h00;
	end

	// Write: one strobe cycle, released data is inverted
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(negedge sys_clk);
		cpu_wr = 1'b0;
		cpu_wdata = ~d;
	endtask

	// Read: data stands the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(negedge sys_clk);
		cpu_rd = 1'b0;
		d = cpu_rdata;
	endtask

	// Write then read the same address on back-to-back cycles
	task automatic wr_rd(input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge sys_clk);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(negedge sys_clk);
		cpu_wr = 1'b0;
		cpu_wdata = ~d;
		cpu_rd = 1'b1;
		@(negedge sys_clk);
		cpu_rd = 1'b0;
		q = cpu_rdata;
	endtask
endmodule // ubr_mcu_model

`default_nettype wire

//--- tb/usb_buffer_ram_and_register_map_bench.sv
`timescale 1ns/1ps
`default_nettype none

module usb_buffer_ram_and_register_map_bench;
	import ubr_pkg::*;
	logic             sys_clk;
	logic             nrst;
	logic [15:0]      cpu_addr;
	logic             cpu_rd;
	logic             cpu_wr;
	logic [7:0]       cpu_wdata;
	logic             cpu_hit;
	logic [7:0]       cpu_rdata;
	logic             eng_req;
	logic             eng_we;
	logic             eng_desc;
	ubr_desc_sel_type eng_sel;
	logic [8:0]       eng_addr;
	logic [7:0]       eng_wdata;
	logic             eng_ready;
	logic             eng_rvalid;
	logic [7:0]       eng_rdata;
	logic [10:0]      eng_buf_start;
	logic [7:0]       sb_data_in;
	logic [7:0]       id_status_in;
	ubr_reg_file_type reg_out;
	ubr_wr_event_type reg_wr;
	int               bad_count;
	int               num_checks;
	int               cyc;
	logic [15:0]      regs [21] = '{16'hff80, 16'hff81, 16'hff82,
		16'hff83, 16'hff84, 16'hff90, 16'hff92, 16'hff93, 16'hff94,
		16'hff95, 16'hff96, 16'hff97, 16'hfff0, 16'hfff1, 16'hfff2,
		16'hfff3, 16'hfff6, 16'hfffc, 16'hfffd, 16'hfffe, 16'hffff};
	logic [15:0]      rsvd [9] = '{16'hff85, 16'hff8f, 16'hff91,
		16'hff98, 16'hffef, 16'hfff4, 16'hfff5, 16'hfff7, 16'hfffb};
	logic [15:0]      ram [9] = '{16'hfd80, 16'hfeef, 16'hfef0,
		16'hfef7, 16'hfef8, 16'hfeff, 16'hff00, 16'hff07, 16'hff7f};

	ubr_external_data_space_decoder uut (
		.sys_clk(sys_clk), .nrst(nrst), .cpu_addr(cpu_addr),
		.cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata),
		.cpu_hit(cpu_hit), .cpu_rdata(cpu_rdata), .eng_req(eng_req),
		.eng_we(eng_we), .eng_desc(eng_desc), .eng_sel(eng_sel),
		.eng_addr(eng_addr), .eng_wdata(eng_wdata),
		.eng_ready(eng_ready), .eng_rvalid(eng_rvalid),
		.eng_rdata(eng_rdata), .eng_buf_start(eng_buf_start),
		.sb_data_in(sb_data_in), .id_status_in(id_status_in),
		.reg_out(reg_out), .reg_wr(reg_wr)
	);

	ubr_mcu_model mcu (
		.cpu_rdata(cpu_rdata), .sys_clk(sys_clk), .cpu_addr(cpu_addr),
		.cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata)
	);

	always #2.5 sys_clk = ~sys_clk;

	task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic stop_test();
		if (bad_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Engine access, held until accepted or for at most 8 cycles
	task automatic eng_op(input logic we, input logic dsc,
		input ubr_desc_sel_type s, input logic [8:0] a,
		input logic [7:0] wd, input int exp_n);
		int n;
		@(negedge sys_clk);
		eng_req = 1'b1;
		eng_we = we;
		eng_desc = dsc;
		eng_sel = s;
		eng_addr = a;
		eng_wdata = wd;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (eng_ready !== 1'b1 && n < 8);
		@(negedge sys_clk);
		eng_req = 1'b0;
		eng_wdata = ~wd;
		chk(11'(n), 11'(exp_n));
		if (!we) chk(11'(eng_rvalid), 11'h001);
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	initial begin
		logic [7:0]  d;
		logic [7:0]  v;
		logic [15:0] a;
		sys_clk = 1'b0;
		nrst = 1'b0;
		bad_count = 0;
		num_checks = 0;
		cyc = 0;
		eng_req = 1'b0;
		eng_we = 1'b0;
		eng_desc = 1'b0;
		eng_sel = '0;
		eng_addr = 9'h000;
		eng_wdata = 8'h00;
		sb_data_in = 8'h3c;
		id_status_in = 8'hc3;
		repeat (16) @(negedge sys_clk);
		for (int i = 0; i < 21; i++) chk(11'(reg_out[i]), 11'h000);
		nrst = 1'b1;
		for (int i = 0; i < 21; i++) begin
			mcu.wr(regs[i], 8'(i * 7 + 1));
			chk(11'({reg_wr.valid, reg_wr.idx}), 11'(32 + i));
			chk(11'(reg_wr.data), 11'(i * 7 + 1));
		end
		for (int i = 0; i < 21; i++) begin
			mcu.rd(regs[i], d);
			v = 8'(i * 7 + 1);
			if (regs[i] == 16'hfff2) v = sb_data_in;
			if (regs[i] == 16'hfff6) v = id_status_in;
			chk(11'(d), 11'(v));
			v = (i == 14 || i == 16) ? 8'h00 : 8'(i * 7 + 1);
			chk(11'(reg_out[i]), 11'(v));
		end
		for (int i = 0; i < 9; i++) begin
			mcu.wr(rsvd[i], 8'hff);
			chk(11'(reg_wr.valid), 11'h000);
			mcu.rd(rsvd[i], d);
			chk(11'(d), 11'h000);
		end
		chk(11'(reg_out[0]), 11'h001);
		mcu.wr_rd(16'hffff, 8'h96, d);
		chk(11'(d), 11'h096);
		mcu.wr_rd(16'hfe00, 8'h3a, d);
		chk(11'(d), 11'h03a);
		for (int i = 0; i < 9; i++) mcu.wr(ram[i], ram[i][7:0] ^ 8'ha5);
		mcu.wr(16'hff80, 8'h77);
		for (int i = 0; i < 9; i++) begin
			mcu.rd(ram[i], d);
			chk(11'(d), 11'(ram[i][7:0] ^ 8'ha5));
			eng_op(1'b0, 1'b0, '0, 9'(ram[i] - 16'hfd80), 8'h00, 1);
			chk(11'(eng_rdata), 11'(ram[i][7:0] ^ 8'ha5));
		end
		eng_op(1'b1, 1'b0, '0, 9'h010, 8'h5c, 1);
		mcu.rd(16'hfd90, d);
		chk(11'(d), 11'h05c);
		chk(11'(cpu_hit), 11'h001);
		mcu.rd(16'hfd7f, d);
		chk(11'(cpu_hit), 11'h000);
		fork
			mcu.wr(16'hfd90, 8'h11);
			eng_op(1'b1, 1'b0, '0, 9'h010, 8'h22, 2);
		join
		mcu.rd(16'hfd90, d);
		chk(11'(d), 11'h022);
		for (int dr = 0; dr < 2; dr++)
			for (int ep = 1; ep < 4; ep++)
				for (int f = 0; f < 8; f++) begin
					a = (dr != 0 ? 16'hff48 : 16'hff08) + 16'(8 * (ep - 1) + f);
					v = {1'(dr), 2'(ep), 3'(f), 2'b10};
					mcu.wr(a, v);
					eng_op(1'b0, 1'b1, ubr_desc_sel_type'(v[7:2]), 9'h000,
						8'h00, 1);
					chk(11'(eng_rdata), 11'(v));
					chk(eng_buf_start, {v, 3'b000});
				end
		@(negedge sys_clk);
		nrst = 1'b0;
		@(negedge sys_clk);
		for (int i = 0; i < 21; i++) chk(11'(reg_out[i]), 11'h000);
		chk(11'(reg_wr.valid), 11'h000);
		chk(11'(cpu_rdata), 11'h000);
		nrst = 1'b1;
		mcu.rd(16'hfd90, d);
		chk(11'(d), 11'h022);
		@(negedge sys_clk);
		eng_req = 1'b1;
		eng_desc = 1'b1;
		eng_sel = ubr_desc_sel_type'(6'b100_001);
		@(posedge sys_clk);
		chk(11'(eng_ready), 11'h000);
		@(negedge sys_clk);
		eng_req = 1'b0;
		stop_test();
	end
endmodule // usb_buffer_ram_and_register_map_bench

`default_nettype wire
